// ==== core/bbt_pkg.sv ====
`default_nettype none
package bbt_pkg;
    // ------------------------------------------------------------
    // Address map and widths
    // ------------------------------------------------------------
    localparam int ADDR_W = 32;
    localparam int PAGE_LSB = 12;
    localparam int PAGE_W = 20;
    localparam int LIMIT_W = 19;
    localparam logic [2:0] SEG_KERNEL_CACHED = 3'h4;
    localparam logic [2:0] SEG_KERNEL_UNCACHED = 3'h5;
    localparam logic [2:0] KSEG_CLEAR_MASK_BITS = 3'h0;
    // ------------------------------------------------------------
    // Cache attribute select: one bit per program address region 31:29
    // ------------------------------------------------------------
    localparam int ATTR_W = 8;
    // Reset: cached window cacheable, uncached window uncached, rest cacheable
    localparam logic [7:0] ATTR_RESET = 8'hdf;
    // ------------------------------------------------------------
    // Translation outcome
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        BBT_FAULT_NONE = 2'b00,
        BBT_FAULT_ADDR = 2'b01,
        BBT_FAULT_BOUND = 2'b10
    } bbt_fault_t;
endpackage
`default_nettype wire

// ==== core/bbt_translate.sv ====
`default_nettype none
// What this block does
// RQ1 - Check bound first, relocate only when in range
// RQ2 - Separate instruction and data relocation pairs
// RQ3 - Use only low 32 address bits
// RQ4 - Physical address is exactly 32 bits
// RQ5 - User segment reachable from user and kernel
// RQ6 - Cached window: clear top three bits
// RQ7 - Cached window cacheable after reset
// RQ8 - Uncached window: clear bits, uncached after reset
// RQ9 - Upper window: clear bits, attribute-driven cacheability
// RQ10 - User access above user segment: address error
// RQ11 - Page above limit raises bound exception
// RQ12 - Physical page equals page plus base
// RQ13 - Address bits 31:29 pick attribute field
// RQ14 - Sum wraps; fault reports instruction or data
module bbt_translate (
    input wire logic clock_in,
    input wire logic resetn_in,
    input wire logic user_mode_in,
    input wire logic instr_valid_in,
    input wire logic [63:0] instr_addr_in,
    input wire logic data_valid_in,
    input wire logic [63:0] data_addr_in,
    input wire logic limit_write_in,
    input wire logic base_write_in,
    input wire logic attr_write_in,
    input wire logic cfg_select_data_in,
    input wire logic [31:0] cfg_value_in,
    output logic [31:0] instr_relocation_base_out,
    output logic [31:0] instr_relocation_limit_out,
    output logic [31:0] data_relocation_base_out,
    output logic [31:0] data_relocation_limit_out,
    output logic [bbt_pkg::ATTR_W-1:0] cache_attribute_select_out,
    output logic instr_phys_valid_out,
    output logic [bbt_pkg::ADDR_W-1:0] instr_phys_addr_out,
    output logic instr_cacheable_out,
    output logic data_phys_valid_out,
    output logic [bbt_pkg::ADDR_W-1:0] data_phys_addr_out,
    output logic data_cacheable_out,
    output logic fault_out,
    output bbt_pkg::bbt_fault_t fault_kind_out,
    output logic fault_is_data_out,
    output logic [bbt_pkg::ADDR_W-1:0] fault_addr_out
);
    import bbt_pkg::*;

    // ------------------------------------------------------------
    // Timing and limits
    // ------------------------------------------------------------
    // Every request is answered at the next rising edge, except a data
    // fault in the cycle of an instruction fault: a valid pulse with the
    // physical address, or a fault pulse, never both on one path.
    // Requests may follow one another on every cycle, and both paths
    // may ask in the same cycle.
    // A configuration write is seen by requests from the next edge
    // on, so a request in the cycle of the write still uses the old
    // pair; the core must leave one cycle between the two.
    // Bit 31 of each limit is kept but never compared, because a
    // user page never has bit 31 set.
    // Address bits 63:32 are dropped at the input and never looked at.

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    logic [31:0] base_r [2];
    logic [31:0] limit_r [2];
    logic [31:0] base_nxt [2];
    logic [31:0] limit_nxt [2];
    logic [ATTR_W-1:0] attr_r;
    logic [ATTR_W-1:0] attr_nxt;

    // Index 0 holds the instruction pair, index 1 the data pair
    always_comb begin
        for (int k = 0; k < 2; k++) begin
            base_nxt[k] = base_r[k];
            limit_nxt[k] = limit_r[k];
            if (base_write_in && (cfg_select_data_in == k[0])) begin
                base_nxt[k] = cfg_value_in; // [RQ2]
            end
            if (limit_write_in && (cfg_select_data_in == k[0])) begin
                limit_nxt[k] = cfg_value_in; // [RQ2]
            end
        end
    end

    // Pairs clear to zero: only page zero is in range until written
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            base_r[0] <= 32'h0;
            base_r[1] <= 32'h0;
            limit_r[0] <= 32'h0;
            limit_r[1] <= 32'h0;
        end else begin
            base_r <= base_nxt;
            limit_r <= limit_nxt;
        end
    end

    // Only the low byte of the write value reaches the attribute fields
    always_comb begin
        attr_nxt = attr_r;
        if (attr_write_in) begin
            attr_nxt = cfg_value_in[ATTR_W-1:0];
        end
    end

    // Attribute reset value gives window defaults [RQ7] [RQ8]
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            attr_r <= ATTR_RESET;
        end else begin
            attr_r <= attr_nxt;
        end
    end

    assign instr_relocation_base_out = base_r[0];
    assign instr_relocation_limit_out = limit_r[0];
    assign data_relocation_base_out = base_r[1];
    assign data_relocation_limit_out = limit_r[1];
    assign cache_attribute_select_out = attr_r;

    // ------------------------------------------------------------
    // Per-path translation, same algorithm on both paths
    // ------------------------------------------------------------
    logic valid_c [2];
    logic [31:0] va_c [2];
    logic [31:0] pa_c [2];
    logic cache_c [2];
    bbt_fault_t fault_c [2];

    assign valid_c[0] = instr_valid_in;
    assign valid_c[1] = data_valid_in;
    assign va_c[0] = instr_addr_in[31:0]; // [RQ3]
    assign va_c[1] = data_addr_in[31:0]; // [RQ3]

    // Segment map by program address bits 31:29:
    // Codes 0xx: user segment, bound check then relocation, any mode
    // Code 100: kernel cached window, direct map
    // Code 101: kernel uncached window, direct map
    // Codes 11x: kernel upper window, direct map
    // Direct map means the top three bits are cleared, nothing more.
    // The bound compare and the page adder run in parallel; the
    // adder result is simply not used when the page is over the limit,
    // which keeps the path short at the cost of an idle adder.
    // A user-mode reference outside the user segment never reaches
    // the windows: it ends as an address error on its own path.
    genvar p;
    generate
        for (p = 0; p < 2; p++) begin : g_path
            logic [PAGE_W-1:0] page_sum;
            logic user_seg;
            logic over_limit;
            // Bit 31 of the limit is outside the compare: user pages never set it
            assign user_seg = ~va_c[p][31];
            assign over_limit = va_c[p][31:PAGE_LSB] >
                {1'b0, limit_r[p][30:PAGE_LSB]}; // [RQ11]
            assign page_sum = va_c[p][31:PAGE_LSB] + base_r[p][31:PAGE_LSB]; // [RQ14]
            always_comb begin
                fault_c[p] = BBT_FAULT_NONE;
                pa_c[p] = 32'h0;
                cache_c[p] = attr_r[va_c[p][31:29]]; // [RQ13] [RQ9]
                if (user_seg) begin
                    // Bound checked before relocation result is used [RQ1] [RQ5]
                    if (over_limit) begin
                        fault_c[p] = BBT_FAULT_BOUND; // [RQ11]
                    end else begin
                        pa_c[p] = {page_sum, va_c[p][PAGE_LSB-1:0]}; // [RQ12] [RQ4]
                    end
                end else if (user_mode_in) begin
                    fault_c[p] = BBT_FAULT_ADDR; // [RQ10]
                end else begin
                    // Kernel windows skip relocation [RQ6] [RQ8] [RQ9]
                    pa_c[p] = {KSEG_CLEAR_MASK_BITS, va_c[p][28:0]};
                end
                if (!valid_c[p]) begin
                    fault_c[p] = BBT_FAULT_NONE;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Registered results, one cycle after the request
    // ------------------------------------------------------------
    // Instruction result registers
    logic ivalid_r;
    logic ivalid_nxt;
    logic icache_r;
    logic icache_nxt;
    logic [31:0] ipa_r;
    logic [31:0] ipa_nxt;
    // Data result registers
    logic dvalid_r;
    logic dvalid_nxt;
    logic dcache_r;
    logic dcache_nxt;
    logic [31:0] dpa_r;
    logic [31:0] dpa_nxt;
    // Fault report registers
    logic fault_r;
    logic fault_nxt;
    logic fdata_r;
    logic fdata_nxt;
    logic [31:0] faddr_r;
    logic [31:0] faddr_nxt;
    bbt_fault_t fkind_r;
    bbt_fault_t fkind_nxt;

    // Instruction answer; a fault keeps the valid low so no access starts
    always_comb begin
        ivalid_nxt = valid_c[0] && (fault_c[0] == BBT_FAULT_NONE);
        ipa_nxt = pa_c[0];
        icache_nxt = cache_c[0];
    end

    // Instruction answer registers
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            ivalid_r <= 1'b0;
            ipa_r <= 32'h0;
            icache_r <= 1'b0;
        end else begin
            ivalid_r <= ivalid_nxt;
            ipa_r <= ipa_nxt;
            icache_r <= icache_nxt;
        end
    end

    // ------------------------------------------------------------
    // Data answer, same shape as the instruction answer
    // ------------------------------------------------------------
    always_comb begin
        dvalid_nxt = valid_c[1] && (fault_c[1] == BBT_FAULT_NONE);
        dpa_nxt = pa_c[1];
        dcache_nxt = cache_c[1];
    end

    // Data answer registers
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            dvalid_r <= 1'b0;
            dpa_r <= 32'h0;
            dcache_r <= 1'b0;
        end else begin
            dvalid_r <= dvalid_nxt;
            dpa_r <= dpa_nxt;
            dcache_r <= dcache_nxt;
        end
    end

    // ------------------------------------------------------------
    // Fault report
    // ------------------------------------------------------------
    // Instruction fault wins the report when both paths fault together;
    // the data fault of that cycle is dropped, so the core must replay it
    always_comb begin
        fault_nxt = 1'b0;
        fkind_nxt = BBT_FAULT_NONE;
        fdata_nxt = 1'b0;
        faddr_nxt = faddr_r;
        if (fault_c[0] != BBT_FAULT_NONE) begin
            fault_nxt = 1'b1;
            fkind_nxt = fault_c[0];
            faddr_nxt = va_c[0];
        end else if (fault_c[1] != BBT_FAULT_NONE) begin
            fault_nxt = 1'b1;
            fkind_nxt = fault_c[1];
            fdata_nxt = 1'b1; // [RQ14]
            faddr_nxt = va_c[1];
        end
    end

    // Fault address holds until the next fault for the handler to read
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            fault_r <= 1'b0;
            fkind_r <= BBT_FAULT_NONE;
            fdata_r <= 1'b0;
            faddr_r <= 32'h0;
        end else begin
            fault_r <= fault_nxt;
            fkind_r <= fkind_nxt;
            fdata_r <= fdata_nxt;
            faddr_r <= faddr_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Straight from the result registers, no logic after the flops
    assign instr_phys_valid_out = ivalid_r;
    assign instr_phys_addr_out = ipa_r;
    assign instr_cacheable_out = icache_r;
    assign data_phys_valid_out = dvalid_r;
    assign data_phys_addr_out = dpa_r;
    assign data_cacheable_out = dcache_r;
    assign fault_out = fault_r;
    assign fault_kind_out = fkind_r;
    assign fault_is_data_out = fdata_r;
    assign fault_addr_out = faddr_r;
endmodule
`default_nettype wire

// ==== dv/bbt_properties.sv ====
`default_nettype none
module bbt_properties (
    input wire logic clock_in,
    input wire logic resetn_in,
    input wire logic user_mode_in,
    input wire logic instr_valid_in,
    input wire logic [63:0] instr_addr_in,
    input wire logic [7:0] cache_attribute_select_out,
    input wire logic instr_phys_valid_out,
    input wire logic [31:0] instr_phys_addr_out,
    input wire logic instr_cacheable_out,
    input wire logic fault_out,
    input wire bbt_pkg::bbt_fault_t fault_kind_out,
    input wire logic fault_is_data_out
);
    timeunit 1ns;
    timeprecision 1ns;
    import bbt_pkg::*;
    logic [31:0] ia_r;
    logic c_r;
    // Request snapshot; the answer lands one edge later
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            ia_r <= '0;
            c_r <= 1'b0;
        end else begin
            ia_r <= instr_addr_in[31:0];
            c_r <= cache_attribute_select_out[instr_addr_in[31:29]];
        end
    end
    default clocking dc @(posedge clock_in);
    endclocking
    default disable iff (!resetn_in);
    // Every instruction request answered in exactly one cycle
    a_addr_err: assert property (instr_valid_in && user_mode_in && instr_addr_in[31] |=>
        fault_out && fault_kind_out == BBT_FAULT_ADDR && !fault_is_data_out)
        else $error("no addr err");
    a_kernel_map: assert property (instr_valid_in && !user_mode_in && instr_addr_in[31] |=>
        instr_phys_addr_out == {3'h0, ia_r[28:0]}) else $error("bad kernel map");
    a_cache_pick: assert property (instr_valid_in |=>
        !instr_phys_valid_out || instr_cacheable_out == c_r) else $error("bad cacheable");
    a_one_answer: assert property (instr_valid_in |=> instr_phys_valid_out || fault_out)
        else $error("no answer");
    a_idle_quiet: assert property (!instr_valid_in |=> !instr_phys_valid_out)
        else $error("spurious valid");
    a_kind_legal: assert property (fault_out |-> fault_kind_out inside {BBT_FAULT_ADDR,
        BBT_FAULT_BOUND}) else $error("bad kind");
    a_user_seg: assert property (instr_valid_in && !instr_addr_in[31] |=> !fault_out ||
        fault_is_data_out || fault_kind_out != BBT_FAULT_ADDR) else $error("user seg refused");
    a_fault_blocks: assert property (fault_out && !fault_is_data_out |->
        !instr_phys_valid_out) else $error("valid with fault");
    c_kernel: cover property (instr_valid_in && !user_mode_in && instr_addr_in[31]);
    c_bound: cover property (fault_out && fault_kind_out == BBT_FAULT_BOUND);
    c_data_fault: cover property (fault_out && fault_is_data_out);
endmodule
bind bbt_translate bbt_properties u_props (.clock_in, .resetn_in, .user_mode_in, .instr_valid_in,
    .instr_addr_in, .cache_attribute_select_out, .instr_phys_valid_out, .instr_phys_addr_out,
    .instr_cacheable_out, .fault_out, .fault_kind_out, .fault_is_data_out);
`default_nettype wire

// ==== dv/bbt_core_model.sv ====
`default_nettype none
module bbt_core_model (
    input wire logic clock_in,
    output logic user_mode_out,
    output logic instr_valid_out,
    output logic [63:0] instr_addr_out,
    output logic data_valid_out,
    output logic [63:0] data_addr_out
);
    timeunit 1ns;
    timeprecision 1ns;
    // One-cycle request, then scramble address lines so stale values never pass
    task automatic issue(input logic u, iv, input logic [63:0] ia,
                         input logic dv, input logic [63:0] da);
        @(negedge clock_in);
        {user_mode_out, instr_valid_out, data_valid_out} = {u, iv, dv};
        {instr_addr_out, data_addr_out} = {ia, da};
        @(negedge clock_in);
        {instr_valid_out, data_valid_out} = 2'h0;
        {instr_addr_out, data_addr_out} = ~{ia, da};
    endtask
    initial begin
        {user_mode_out, instr_valid_out, data_valid_out} = 3'h0;
        {instr_addr_out, data_addr_out} = '0;
    end
endmodule
`default_nettype wire

// ==== dv/tb_top.sv ====
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import bbt_pkg::*;
    typedef struct {
        logic u;
        logic d;
        logic [63:0] a;
        logic [1:0] k;
        logic [31:0] p;
        logic c;
    } bbt_row_t;
    logic clock_in = 1'b0, resetn_in = 1'b0, user_mode_in, instr_valid_in, data_valid_in;
    logic limit_write_in = 1'b0, base_write_in = 1'b0, attr_write_in = 1'b0;
    logic cfg_select_data_in = 1'b0;
    logic [31:0] instr_relocation_limit_out, data_relocation_limit_out, fault_addr_out;
    logic [63:0] instr_addr_in, data_addr_in;
    logic [31:0] cfg_value_in = '0, instr_relocation_base_out, data_relocation_base_out;
    logic [31:0] instr_phys_addr_out, data_phys_addr_out;
    logic [7:0] cache_attribute_select_out;
    logic instr_phys_valid_out, instr_cacheable_out, data_phys_valid_out, data_cacheable_out;
    logic fault_out, fault_is_data_out;
    bbt_fault_t fault_kind_out;
    int n_mismatch = 0, n_checks = 0;
    bbt_row_t rows[10] = '{
        '{1'b1, 1'b0, 64'h1234, 2'h0, 32'h10001234, 1'b1},
        '{1'b1, 1'b0, 64'hffffffff_00fff008, 2'h0, 32'h10fff008, 1'b1},
        '{1'b1, 1'b0, 64'h01000000, 2'h2, 32'h0, 1'b0},
        '{1'b1, 1'b0, 64'h80000000, 2'h1, 32'h0, 1'b0},
        '{1'b0, 1'b0, 64'h90000040, 2'h0, 32'h10000040, 1'b1},
        '{1'b0, 1'b0, 64'ha0000010, 2'h0, 32'h10, 1'b0},
        '{1'b0, 1'b0, 64'hc0000004, 2'h0, 32'h4, 1'b1},
        '{1'b0, 1'b0, 64'h1000, 2'h0, 32'h10001000, 1'b1},
        '{1'b1, 1'b1, 64'h2abc, 2'h0, 32'h1abc, 1'b1},
        '{1'b1, 1'b1, 64'h80000000, 2'h1, 32'h0, 1'b0}};
    always #5 clock_in = ~clock_in;
    bbt_core_model core (.clock_in, .user_mode_out(user_mode_in), .instr_valid_out(instr_valid_in),
        .instr_addr_out(instr_addr_in), .data_valid_out(data_valid_in), .data_addr_out(data_addr_in));
    bbt_translate uut (.clock_in, .resetn_in, .user_mode_in, .instr_valid_in, .instr_addr_in,
        .data_valid_in, .data_addr_in, .limit_write_in, .base_write_in, .attr_write_in,
        .cfg_select_data_in, .cfg_value_in, .instr_relocation_base_out,
        .instr_relocation_limit_out, .data_relocation_base_out, .data_relocation_limit_out,
        .cache_attribute_select_out, .instr_phys_valid_out, .instr_phys_addr_out,
        .instr_cacheable_out, .data_phys_valid_out, .data_phys_addr_out, .data_cacheable_out,
        .fault_out, .fault_kind_out, .fault_is_data_out, .fault_addr_out);
    task automatic chk(input string n, input logic [31:0] e, g);
        n_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    // Config pulse: {limit, base, attr} strobes for one cycle
    task automatic cfg(input logic [2:0] w, input logic s, input logic [31:0] v);
        @(negedge clock_in);
        {limit_write_in, base_write_in, attr_write_in, cfg_select_data_in, cfg_value_in} = {w, s, v};
        @(negedge clock_in);
        {limit_write_in, base_write_in, attr_write_in} = 3'h0;
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge clock_in);
        @(negedge clock_in);
        resetn_in = 1'b1;
        chk("attr_reset", 32'hdf, {24'h0, cache_attribute_select_out});
        cfg(3'h4, 1'b0, 32'h00ffffff);
        cfg(3'h2, 1'b0, 32'h10000000);
        cfg(3'h4, 1'b1, 32'h00ffffff);
        cfg(3'h2, 1'b1, 32'hfffff000);
        chk("data_base", 32'hfffff000, data_relocation_base_out);
        chk("instr_base", 32'h10000000, instr_relocation_base_out);
        chk("instr_limit", 32'h00ffffff, instr_relocation_limit_out);
        chk("data_limit", 32'h00ffffff, data_relocation_limit_out);
        foreach (rows[i]) begin
            core.issue(rows[i].u, !rows[i].d, rows[i].a, rows[i].d, rows[i].a);
            chk("valid", {31'h0, rows[i].k == 2'h0},
                {31'h0, rows[i].d ? data_phys_valid_out : instr_phys_valid_out});
            if (rows[i].k != 2'h0) begin
                chk("fault", {29'h0, rows[i].k, rows[i].d},
                    {29'h0, fault_kind_out, fault_is_data_out});
                chk("fault_addr", rows[i].a[31:0], fault_addr_out);
            end else begin
                chk("phys", rows[i].p,
                    rows[i].d ? data_phys_addr_out : instr_phys_addr_out);
            end
            if (rows[i].k == 2'h0)
                chk("cache", {31'h0, rows[i].c},
                    {31'h0, rows[i].d ? data_cacheable_out : instr_cacheable_out});
        end
        cfg(3'h1, 1'b0, 32'h00000020);
        core.issue(1'b0, 1'b1, 64'ha0000010, 1'b0, 64'h0);
        chk("uncached_win", 32'h1, {31'h0, instr_cacheable_out});
        core.issue(1'b1, 1'b1, 64'h80000000, 1'b1, 64'h80000004);
        chk("both_fault", 32'h4, {29'h0, fault_out, fault_is_data_out, data_phys_valid_out});
        chk("both_fault_addr", 32'h80000000, fault_addr_out);
        @(negedge clock_in);
        resetn_in = 1'b0;
        @(negedge clock_in);
        chk("attr_rereset", 32'hdf, {24'h0, cache_attribute_select_out});
        conclude();
    end
    initial begin
        #20000;
        n_mismatch++;
        conclude();
    end
endmodule
`default_nettype wire
